// [inc/adcs_pkg.sv]
// Shared constants for the conversion sequencer: timing, word layout and states.
package adcs_pkg;
  // System clock rate that the periods and the start-up wait below are converted against.
  localparam int CLK_HZ           = 50_000_000;
  // Conversion periods per filter, in milliseconds.
  localparam int SLOW_PERIOD_MS   = 100;
  localparam int FAST_PERIOD_MS   = 60;
  // Filter settling times, in milliseconds, and the conversion cycles they span.
  localparam int SLOW_SETTLE_MS   = 300;
  localparam int FAST_SETTLE_MS   = 120;
  localparam int SLOW_SETTLE_CONV = SLOW_SETTLE_MS / SLOW_PERIOD_MS;
  localparam int FAST_SETTLE_CONV = FAST_SETTLE_MS / FAST_PERIOD_MS;
  // Internal oscillator start-up wait, in microseconds.
  localparam int CLK_START_US     = 1000;
  // Derived cycle counts; all exceed 4096 and are overridable on the top module.
  localparam int SLOW_PERIOD_CYC  = SLOW_PERIOD_MS * (CLK_HZ / 1000);
  localparam int FAST_PERIOD_CYC  = FAST_PERIOD_MS * (CLK_HZ / 1000);
  localparam int CLK_START_CYC    = CLK_START_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W            = 24;
  localparam int CONV_CNT_W       = 2;
  // Result word layout: value, zero pad, then an eight-bit status byte.
  localparam int RESULT_BITS      = 20;
  localparam int PAD_BITS         = 4;
  localparam int WORD_BITS        = 32;
  localparam int BIT_CNT_W        = 6;
  localparam int ST_RDY           = 7;
  localparam int ST_FILTER        = 6;
  localparam int ST_ERR           = 5;
  localparam int ST_ID_LSB        = 3;
  localparam int ST_GAIN          = 2;
  localparam int ST_PAT_LSB       = 0;
  // Sequencer states, Gray coded along off, start-up, settle, run.
  typedef enum logic [1:0] {
    ST_OFF     = 2'h0,
    ST_STARTUP = 2'h1,
    ST_SETTLE  = 2'h3,
    ST_RUN     = 2'h2
  } adcs_state_t;
endpackage : adcs_pkg

// [rtl/adcs_shifter.sv]
// Result word holder and serial shifter driven by sampled serial clock edges.
`timescale 1ns/100ps
module adcs_shifter #(
  parameter int WORD_W = adcs_pkg::WORD_BITS
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clr,
  input  wire logic              load,
  input  wire logic [WORD_W-1:0] word_in,
  input  wire logic              sclk_rise,
  input  wire logic              sclk_fall,
  output logic                   bit_out,
  output logic                   done
);
  logic [WORD_W-1:0]              sreg_reg, sreg_next;
  logic [adcs_pkg::BIT_CNT_W-1:0] cnt_reg, cnt_next;
  logic                           started_reg, started_next;
  logic                           bit_reg, bit_next;
  logic                           done_reg, done_next;

  // A load restarts the interface, so a half-read old word is simply abandoned.
  always_comb
  begin
    sreg_next    = sreg_reg;
    cnt_next     = cnt_reg;
    started_next = started_reg;
    bit_next     = bit_reg;
    done_next    = 1'b0;
    if (clr || load)
    begin
      sreg_next    = load ? word_in : '0;
      cnt_next     = '0;
      started_next = 1'b0;
      bit_next     = 1'b0;
    end
    else if (sclk_fall && cnt_reg < adcs_pkg::BIT_CNT_W'(WORD_W))
    begin
      started_next = 1'b1;
      if (started_reg)
      begin
        sreg_next = {sreg_reg[WORD_W-2:0], 1'b0};
        bit_next  = sreg_reg[WORD_W-2];
      end
      else
      begin
        bit_next = sreg_reg[WORD_W-1];
      end
    end
    else if (sclk_rise && started_reg && cnt_reg < adcs_pkg::BIT_CNT_W'(WORD_W))
    begin
      cnt_next  = cnt_reg + 1'b1;
      done_next = (cnt_reg == adcs_pkg::BIT_CNT_W'(WORD_W - 1));
    end
  end

  // Shifter state registers.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sreg_reg    <= '0;
      cnt_reg     <= '0;
      started_reg <= 1'b0;
      bit_reg     <= 1'b0;
      done_reg    <= 1'b0;
    end
    else
    begin
      sreg_reg    <= sreg_next;
      cnt_reg     <= cnt_next;
      started_reg <= started_next;
      bit_reg     <= bit_next;
      done_reg    <= done_next;
    end
  end

  assign bit_out = bit_reg;
  assign done    = done_reg;
endmodule : adcs_shifter

// [rtl/adcs_sequencer.sv]
// Conversion sequencer: rate and gain select, settling, power-down and ready line.
// Function
// - Filter pin low 16.7 Hz, high 10 Hz.
// - Filter change resets modulator, restarts conversions.
// - Settling: three slow periods, two fast periods.
// - First result after full settling, then periodic.
// - Ready line high throughout settling after change.
// - Gain pin low 128, high 1.
// - Gain change resets and resettles like filter.
// - Power-down: clock off, switch open, output released.
// - Power-down resets logic, interface, filter, modulator.
// - After power-up wait oscillator start, then enable.
// - Full internal reset at supply power-up.
// - Every completed conversion updates the data register.
// - Ready line low when new result present.
// - Word: 20-bit value, four zeros, status byte.
// - Each result readable once; read ends ready.
`timescale 1ns/100ps
module adcs_sequencer #(
  parameter int         SLOW_PERIOD_CYC = adcs_pkg::SLOW_PERIOD_CYC,
  parameter int         FAST_PERIOD_CYC = adcs_pkg::FAST_PERIOD_CYC,
  parameter int         CLK_START_CYC   = adcs_pkg::CLK_START_CYC,
  parameter int         RESULT_W        = adcs_pkg::RESULT_BITS,
  parameter logic [1:0] ID_CODE         = 2'h2, // Arbitrary identity value.
  parameter logic [1:0] PAT_CODE        = 2'h1  // Arbitrary check pattern.
) (
  input  wire logic                SYS_CLK,
  input  wire logic                RST,
  input  wire logic                POWERDOWN_RESET_N,
  input  wire logic                FILTER_SEL,
  input  wire logic                GAIN_SEL,
  input  wire logic                SCLK,
  input  wire logic [RESULT_W-1:0] CONV_RESULT,
  input  wire logic                CONV_OVERRANGE,
  output logic                     DOUT_RDY_N_O,
  output logic                     DOUT_RDY_N_OE,
  output logic                     BRIDGE_LOW_SIDE_SWITCH,
  output logic                     MOD_RESET,
  output logic                     FILTER_10HZ,
  output logic                     GAIN_128
);
  localparam int CW = adcs_pkg::CNT_W;
  localparam int VW = adcs_pkg::CONV_CNT_W;

  adcs_pkg::adcs_state_t        state_reg, state_next;
  logic [CW-1:0]                cnt_reg, cnt_next;
  logic [VW-1:0]                conv_reg, conv_next;
  logic                         filt_reg, filt_next, gain_reg, gain_next;
  logic                         ready_reg, ready_next, sclk_reg;
  logic                         dout_reg, dout_next, oe_reg, oe_next, sw_reg, sw_next, mrst_reg, mrst_next;
  logic                         load, tick, pre_tick, sel_change, sh_bit, sh_done;
  logic [CW-1:0]                period;
  logic [VW-1:0]                settle_conv;
  logic [adcs_pkg::WORD_BITS-1:0] word;

  // Period and settling length follow the currently latched filter choice.
  always_comb
  begin
    period      = filt_reg ? CW'(SLOW_PERIOD_CYC) : CW'(FAST_PERIOD_CYC);
    settle_conv = filt_reg ? VW'(adcs_pkg::SLOW_SETTLE_CONV) : VW'(adcs_pkg::FAST_SETTLE_CONV);
    tick        = (cnt_reg == period - 1'b1);
    pre_tick    = (cnt_reg == period - 2'h2);
    sel_change  = (FILTER_SEL != filt_reg) || (GAIN_SEL == gain_reg);
  end

  // Result word: value, zero pad, then status byte with ready bit cleared.
  always_comb
  begin
    word = {CONV_RESULT, {adcs_pkg::PAD_BITS{1'b0}}, 8'h00};
    word[adcs_pkg::ST_RDY]                  = 1'b0;
    word[adcs_pkg::ST_FILTER]               = filt_reg;
    word[adcs_pkg::ST_ERR]                  = CONV_OVERRANGE;
    word[adcs_pkg::ST_ID_LSB +: 2]          = ID_CODE;
    word[adcs_pkg::ST_GAIN]                 = !gain_reg;
    word[adcs_pkg::ST_PAT_LSB +: 2]         = PAT_CODE;
  end

  // Sequencer next state: power gating, oscillator wait, settling and free run.
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 1'b1;
    conv_next  = conv_reg;
    filt_next  = FILTER_SEL;
    gain_next  = !GAIN_SEL; // Held as a gain-128 flag so the pin output needs no gate.
    ready_next = ready_reg;
    load       = 1'b0;
    mrst_next  = 1'b0;
    sw_next    = 1'b1;
    oe_next    = 1'b1;
    case (state_reg)
      adcs_pkg::ST_OFF:
      begin
        cnt_next   = '0;
        conv_next  = '0;
        ready_next = 1'b0;
        mrst_next  = 1'b1;
        sw_next    = 1'b0;
        oe_next    = 1'b0;
        if (POWERDOWN_RESET_N)
          state_next = adcs_pkg::ST_STARTUP;
      end
      adcs_pkg::ST_STARTUP:
      begin
        mrst_next = 1'b1;
        sw_next   = 1'b0;
        oe_next   = 1'b0;
        if (cnt_reg == CW'(CLK_START_CYC - 1))
        begin
          cnt_next   = '0;
          conv_next  = '0;
          sw_next    = 1'b1;
          oe_next    = 1'b1;
          mrst_next  = 1'b0;
          state_next = adcs_pkg::ST_SETTLE;
        end
      end
      adcs_pkg::ST_SETTLE:
      begin
        ready_next = 1'b0;
        if (tick)
        begin
          cnt_next  = '0;
          conv_next = conv_reg + 1'b1;
          if (conv_reg == settle_conv - 1'b1)
          begin
            load       = 1'b1;
            ready_next = 1'b1;
            state_next = adcs_pkg::ST_RUN;
          end
        end
      end
      adcs_pkg::ST_RUN:
      begin
        if (sh_done)
          ready_next = 1'b0;
        if (pre_tick)
          ready_next = 1'b0; // Blank the line just before the register changes.
        if (tick)
        begin
          cnt_next   = '0;
          load       = 1'b1;
          ready_next = 1'b1;
        end
      end
      default:
      begin
        state_next = adcs_pkg::ST_OFF;
      end
    endcase
    // A select change restarts settling from the top, whatever the run phase.
    if ((state_reg == adcs_pkg::ST_SETTLE || state_reg == adcs_pkg::ST_RUN) && sel_change)
    begin
      state_next = adcs_pkg::ST_SETTLE;
      cnt_next   = '0;
      conv_next  = '0;
      ready_next = 1'b0;
      load       = 1'b0;
      mrst_next  = 1'b1;
    end
    // Power-down overrides everything but the filter and gain latches, which keep following their pins, and holds the rest of the block in reset.
    if (!POWERDOWN_RESET_N)
    begin
      state_next = adcs_pkg::ST_OFF;
      cnt_next   = '0;
      conv_next  = '0;
      ready_next = 1'b0;
      load       = 1'b0;
      mrst_next  = 1'b1;
      sw_next    = 1'b0;
      oe_next    = 1'b0;
    end
    // Ones are read whenever no fresh result is pending; a load shows low at once, never a stale bit.
    dout_next = ready_next ? (load ? 1'b0 : sh_bit) : 1'b1;
  end

  // Sequencer registers; the asynchronous reset doubles as the power-on reset.
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= adcs_pkg::ST_OFF;
      cnt_reg   <= '0;
      conv_reg  <= '0;
      filt_reg  <= 1'b0;
      gain_reg  <= 1'b1;
      ready_reg <= 1'b0;
      sclk_reg  <= 1'b1;
      dout_reg  <= 1'b1;
      oe_reg    <= 1'b0;
      sw_reg    <= 1'b0;
      mrst_reg  <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      conv_reg  <= conv_next;
      filt_reg  <= filt_next;
      gain_reg  <= gain_next;
      ready_reg <= ready_next;
      sclk_reg  <= SCLK;
      dout_reg  <= dout_next;
      oe_reg    <= oe_next;
      sw_reg    <= sw_next;
      mrst_reg  <= mrst_next;
    end
  end

  // The shifter is cleared by any modulator reset so no stale word survives.
  adcs_shifter #(
    .WORD_W    (adcs_pkg::WORD_BITS)
  ) u_shifter (
    .clk       (SYS_CLK),
    .rst       (RST),
    .clr       (mrst_next),
    .load      (load),
    .word_in   (word),
    .sclk_rise (SCLK && !sclk_reg),
    .sclk_fall (!SCLK && sclk_reg),
    .bit_out   (sh_bit),
    .done      (sh_done)
  );

  assign DOUT_RDY_N_O           = dout_reg;
  assign DOUT_RDY_N_OE          = oe_reg;
  assign BRIDGE_LOW_SIDE_SWITCH = sw_reg;
  assign MOD_RESET              = mrst_reg;
  assign FILTER_10HZ            = filt_reg;
  assign GAIN_128               = gain_reg;

  // Checks on the sequencing.
  property p_filter_follow;
    @(posedge SYS_CLK) disable iff (RST) 1'b1 |=> (FILTER_10HZ == $past(FILTER_SEL));
  endproperty
  a_filter_follow: assert property (p_filter_follow) else $error("Filter select not applied.");

  property p_sel_restart;
    @(posedge SYS_CLK) disable iff (RST)
      (POWERDOWN_RESET_N && (state_reg == adcs_pkg::ST_RUN) && (FILTER_SEL != filt_reg))
      |=> (state_reg == adcs_pkg::ST_SETTLE) && MOD_RESET && (DOUT_RDY_N_O || !DOUT_RDY_N_OE);
  endproperty
  a_sel_restart: assert property (p_sel_restart) else $error("Filter change did not restart.");

  property p_settle_bound;
    @(posedge SYS_CLK) disable iff (RST) (state_reg == adcs_pkg::ST_SETTLE) |-> (conv_reg < settle_conv);
  endproperty
  a_settle_bound: assert property (p_settle_bound) else $error("Settling overran its cycle count.");

  property p_first_result;
    @(posedge SYS_CLK) disable iff (RST)
      $rose(ready_reg) |-> $past(state_reg == adcs_pkg::ST_RUN) || $past(conv_reg == settle_conv - 1'b1);
  endproperty
  a_first_result: assert property (p_first_result) else $error("Result before settling ended.");

  property p_settle_high;
    @(posedge SYS_CLK) disable iff (RST)
      (state_reg == adcs_pkg::ST_SETTLE) ##1 (state_reg == adcs_pkg::ST_SETTLE) |-> DOUT_RDY_N_O;
  endproperty
  a_settle_high: assert property (p_settle_high) else $error("Ready line low during settling.");

  property p_gain_map;
    @(posedge SYS_CLK) disable iff (RST) 1'b1 |=> (GAIN_128 == !$past(GAIN_SEL));
  endproperty
  a_gain_map: assert property (p_gain_map) else $error("Gain select not applied.");

  property p_powerdown;
    @(posedge SYS_CLK) disable iff (RST)
      !POWERDOWN_RESET_N |=> !DOUT_RDY_N_OE && !BRIDGE_LOW_SIDE_SWITCH && MOD_RESET && !ready_reg;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("Power-down not honoured.");

  property p_startup_quiet;
    @(posedge SYS_CLK) disable iff (RST)
      (state_reg == adcs_pkg::ST_STARTUP) |-> !DOUT_RDY_N_OE && !BRIDGE_LOW_SIDE_SWITCH;
  endproperty
  a_startup_quiet: assert property (p_startup_quiet) else $error("Output enabled before clock start.");

  property p_ready_low;
    @(posedge SYS_CLK) disable iff (RST) $rose(ready_reg) && !sh_done |-> DOUT_RDY_N_O == sh_bit ##0 !DOUT_RDY_N_O;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("Ready line not low on new result.");

  property p_read_once;
    @(posedge SYS_CLK) disable iff (RST)
      sh_done && !tick && !sel_change && POWERDOWN_RESET_N |=> !ready_reg ##1 DOUT_RDY_N_O;
  endproperty
  a_read_once: assert property (p_read_once) else $error("Result readable twice.");

  c_first_result: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(ready_reg));
  c_full_read:    cover property (@(posedge SYS_CLK) disable iff (RST) sh_done);
  c_gain_change:  cover property (@(posedge SYS_CLK) disable iff (RST)
                    (state_reg == adcs_pkg::ST_RUN) && (GAIN_SEL == gain_reg));
endmodule : adcs_sequencer

// [bench/adcs_host_model.sv]
// Host model that reads result words over the serial clock and the ready/data line.
`timescale 1ns/100ps
module adcs_host_model #(
  parameter int HALF_CYC = 4
) (
  input  wire logic sys_clk,
  input  wire logic dout_line,
  output logic      sclk
);
  // The serial clock idles high and only toggles inside a read.
  initial sclk = 1'b1;

  // Shift one word out, first bit first, sampling the line on each rising serial edge.
  // The bench only calls this with no select change pending, so no read straddles one.
  // Each phase lasts several system clocks because the device samples the serial clock.
  task automatic read_word(output logic [31:0] word);
    int i;
    for (i = 31; i >= 0; i--)
    begin
      @(posedge sys_clk);
      #1 sclk = 1'b0;
      repeat (HALF_CYC) @(posedge sys_clk);
      #1 sclk = 1'b1;
      word[i] = dout_line;
      repeat (HALF_CYC - 1) @(posedge sys_clk);
    end
  endtask : read_word
endmodule : adcs_host_model

// [bench/tb_top.sv]
// Self-checking bench for the conversion sequencer with a serial host model.
`timescale 1ns/100ps
module tb_top;
  // Shortened periods; a read of 32 bits must still fit inside the fast period.
  localparam int         SLOW_P  = 600;
  localparam int         FAST_P  = 400;
  localparam int         START_C = 20;
  localparam logic [1:0] ID_VAL  = 2'h1; // Arbitrary identity value.
  localparam logic [1:0] PAT_VAL = 2'h2; // Arbitrary check pattern.

  logic                                 sys_clk;
  logic                                 rst;
  logic                                 pd_n;
  logic                                 filter_sel;
  logic                                 gain_sel;
  logic                                 overrange;
  logic [adcs_pkg::RESULT_BITS-1:0]     conv_result;
  logic                                 sclk;
  logic                                 dout_o;
  logic                                 dout_oe;
  logic                                 bridge_sw;
  logic                                 mod_reset;
  logic                                 filter_10hz;
  logic                                 gain_128;
  wire logic                            dout_line;
  int                                   fail_count;
  int                                   checks_done;

  // The line floats whenever the device lets go of it.
  assign dout_line = dout_oe ? dout_o : 1'bz;

  adcs_sequencer #(
    .SLOW_PERIOD_CYC (SLOW_P),
    .FAST_PERIOD_CYC (FAST_P),
    .CLK_START_CYC   (START_C),
    .ID_CODE         (ID_VAL),
    .PAT_CODE        (PAT_VAL)
  ) dut_u (
    .SYS_CLK                (sys_clk),
    .RST                    (rst),
    .POWERDOWN_RESET_N      (pd_n),
    .FILTER_SEL             (filter_sel),
    .GAIN_SEL               (gain_sel),
    .SCLK                   (sclk),
    .CONV_RESULT            (conv_result),
    .CONV_OVERRANGE         (overrange),
    .DOUT_RDY_N_O           (dout_o),
    .DOUT_RDY_N_OE          (dout_oe),
    .BRIDGE_LOW_SIDE_SWITCH (bridge_sw),
    .MOD_RESET              (mod_reset),
    .FILTER_10HZ            (filter_10hz),
    .GAIN_128               (gain_128)
  );

  adcs_host_model host_u (
    .sys_clk   (sys_clk),
    .dout_line (dout_line),
    .sclk      (sclk)
  );

  // Clock at 50 MHz.
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_span(string what, int lo, int hi, int got);
    checks_done++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_span

  // Expected word: value, four zeros, then ready, filter, error, identity, gain, pattern.
  function automatic logic [31:0] exp_word(logic [19:0] res, logic f, logic e, logic g);
    return {res, 4'h0, 1'b0, f, e, ID_VAL, g, PAT_VAL};
  endfunction : exp_word

  // Counts cycles until the enabled line shows the wanted level; the limit stops a hang.
  task automatic wait_level(logic lvl, int limit, output int n);
    n = 0;
    while (!(dout_oe === 1'b1 && dout_o === lvl) && n < limit)
    begin
      @(posedge sys_clk);
      #2;
      n++;
    end
  endtask : wait_level

  // Reads one word, compares it and checks that the line returns high after the read.
  task automatic check_word(logic [31:0] exp);
    logic [31:0] w;
    host_u.read_word(w);
    chk("result word", exp, w);
    repeat (3) @(posedge sys_clk);
    #2 chk("line after read", 32'h1, dout_o);
  endtask : check_word

  // Power-up start-up wait, then full settling of the slow filter before the first word.
  task automatic t_startup();
    int n;
    n = 0;
    while (dout_oe !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    chk_span("start-up wait", START_C, START_C + 3, n);
    chk("switch closed", 32'h1, bridge_sw);
    chk("filter out", 32'h1, filter_10hz);
    chk("gain out", 32'h1, gain_128);
    wait_level(1'b0, 4 * SLOW_P, n);
    chk_span("slow settle", 3 * SLOW_P - 2, 3 * SLOW_P + 3, n);
    check_word(exp_word(conv_result, 1'b1, 1'b1, 1'b0));
    check_word(32'hFFFFFFFF);
  endtask : t_startup

  // An unread word is replaced by the next conversion one period later.
  task automatic t_period();
    int n1;
    int n2;
    wait_level(1'b0, 2 * SLOW_P, n1);
    // The input steps just after a conversion ends, so only the next word is trusted.
    @(posedge sys_clk);
    #1 conv_result = 20'h3C5A1;
    overrange = 1'b0;
    wait_level(1'b1, 2 * SLOW_P, n1);
    wait_level(1'b0, 2 * SLOW_P, n2);
    chk_span("update period", SLOW_P - 1, SLOW_P + 1, n1 + n2 + 1);
    check_word(exp_word(20'h3C5A1, 1'b1, 1'b0, 1'b0));
  endtask : t_period

  // A select change with a word pending drops the ready state and resettles.
  task automatic t_select(logic f, logic g);
    int n;
    logic mr;
    wait_level(1'b0, 2 * SLOW_P, n);
    @(posedge sys_clk);
    #1 filter_sel = f;
    gain_sel = g;
    mr = 1'b0;
    repeat (2)
    begin
      @(posedge sys_clk);
      #2 mr = mr | mod_reset;
    end
    chk("line after change", 32'h1, dout_o);
    chk("modulator reset", 32'h1, mr);
    chk("filter out", f, filter_10hz);
    chk("gain out", !g, gain_128);
    wait_level(1'b0, 4 * FAST_P, n);
    chk_span("fast settle", 2 * FAST_P, 2 * FAST_P + 5, n + 2);
    check_word(exp_word(conv_result, f, overrange, g));
  endtask : t_select

  // Power-down releases the line, opens the switch and restarts from scratch.
  task automatic t_powerdown();
    int n;
    @(posedge sys_clk);
    #1 pd_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2 chk("enable in power-down", 32'h0, dout_oe);
    chk("line released", {31'h0, 1'hZ}, {31'h0, dout_line});
    chk("switch open", 32'h0, bridge_sw);
    chk("modulator held", 32'h1, mod_reset);
    // The host keeps the pin low well past the minimum width.
    repeat (8) @(posedge sys_clk);
    #1 pd_n = 1'b1;
    n = 0;
    while (dout_oe !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    chk_span("restart wait", START_C, START_C + 3, n);
    chk("line high at restart", 32'h1, dout_o);
    wait_level(1'b0, 4 * FAST_P, n);
    chk_span("restart settle", 2 * FAST_P - 2, 2 * FAST_P + 3, n);
    check_word(exp_word(conv_result, 1'b0, 1'b0, 1'b1));
  endtask : t_powerdown

  task automatic close_out();
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Main sequence; reset outputs are checked while reset is still held.
  initial
  begin
    fail_count = 0;
    checks_done = 0;
    rst = 1'b1;
    pd_n = 1'b1;
    filter_sel = 1'b1;
    gain_sel = 1'b0;
    overrange = 1'b1;
    conv_result = 20'hA5C3E;
    repeat (5) @(posedge sys_clk);
    #2 chk("enable in reset", 32'h0, dout_oe);
    chk("line in reset", 32'h1, dout_o);
    chk("switch in reset", 32'h0, bridge_sw);
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_startup();
    t_period();
    t_select(1'b0, 1'b0);
    t_select(1'b0, 1'b1);
    t_powerdown();
    close_out();
  end

  // Watchdog well beyond the expected run of about 7000 cycles.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    close_out();
  end
endmodule : tb_top
